/* hdl/isa_decode_pkg.sv */
package isa_decode_pkg;

  // Factory switch values: base 0x2B0, no wait, segment 0xD000
  localparam logic [4:0] IO_BASE_FACTORY = 5'h0B;
  localparam logic [1:0] WAIT_FACTORY = 2'h0;
  localparam logic [4:0] MEM_SEG_FACTORY = 5'h14;

  // I/O window: A9 set, A15..A10 clear, A8..A4 from switches
  localparam int IO_TOP_BIT = 9;
  localparam int IO_HI_MSB = 15;
  localparam logic [3:0] DOUT_LO_OFS = 4'h0;
  localparam logic [3:0] DOUT_HI_OFS = 4'h1;
  localparam int CTRL_SEL_BIT = 3;

  // Memory window: A19 set, A18..A14 from switches, A13..A0 inside
  localparam int MEM_TOP_BIT = 19;
  localparam logic [13:0] ROM_LIMIT = 14'h2000;
  localparam logic [13:0] RAM_BASE = 14'h2000;
  localparam logic [13:0] RAM_LIMIT = 14'h2800;

  // Wait-state timing: one bus clock of 125 ns at a 20 ns core clock
  localparam int CORE_CLK_NS = 20;
  localparam int BUS_CLK_NS = 125;
  localparam int BUS_CLK_DIV = (BUS_CLK_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;

  // DMA channels 1..3, interrupt levels 2..7
  localparam logic [2:0] DMA_CH_FACTORY = 3'h1;
  localparam logic [2:0] DMA_CH_MIN = 3'h1;
  localparam logic [2:0] DMA_CH_MAX = 3'h3;
  localparam logic [2:0] IRQ_FACTORY = 3'h7;
  localparam logic [2:0] IRQ_MIN = 3'h2;
  localparam logic [2:0] IRQ_MAX = 3'h7;

  // APB register map
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CONTROL = 8'h04;
  localparam logic [7:0] REG_ROUTE = 8'h08;
  localparam logic [1:0] CONTROL_RESET = 2'h3;
  localparam int ROUTE_IRQ_LSB = 4;

  // Card-side selects handed to the output port and controller chip
  typedef struct packed {
    logic dout_lo;
    logic dout_hi;
    logic ctrl_cs;
    logic [2:0] ctrl_reg;
    logic rom_cs;
    logic ram_cs;
    logic [12:0] mem_ofs;
    logic rd;
    logic wr;
  } decode_s;

endpackage

/* hdl/isa_card_decoder.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - I/O base selectable from 0x200 to 0x3F0
// - A8..A4 compared; closed switch 0, open 1
// - Sixteen consecutive ports from the base
// - Offsets 0 and 1 select output bytes
// - Offsets 8..15 select controller registers
// - Factory inputs give base 0x2B0, no wait
// - Setting 00/01/10/11 gives 0/2/4/6 waits
// - Memory segment 0x8000..0xFC00 from A18..A14
// - A19 must be 1; A13..A0 pick ROM or RAM
// - Factory inputs give memory segment 0xD000
// - 10K window: 8K ROM, 2K RAM
// - DMA request and acknowledge share one channel
// - Controller interrupt onto one level 2..7
module isa_card_decoder
  import isa_decode_pkg::*;
#(
  parameter int BUS_DIV = BUS_CLK_DIV
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Host bus pins
  input wire logic [19:0] sa_i,
  input wire logic ior_n_i,
  input wire logic iow_n_i,
  input wire logic memr_n_i,
  input wire logic memw_n_i,
  input wire logic aen_i,
  input wire logic [3:1] dack_n_i,
  output logic [3:1] dma_req_o,
  output logic [7:2] irq_line_o,
  output logic chrdy_o,
  output logic chrdy_oe_n_o,
  // Configuration switches
  input wire logic [4:0] io_base_wait_switch_i,
  input wire logic [1:0] wait_count_switch_i,
  input wire logic [4:0] memory_segment_switch_i,
  // Controller chip side
  input wire logic ctrl_drq_i,
  input wire logic ctrl_irq_i,
  output logic ctrl_dack_o,
  output decode_s decode_o,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  if (BUS_DIV < 1)
  begin : g_chk
    $error("BUS_DIV must be at least one");
  end

  localparam int SW = 42;
  localparam int DW = $clog2(BUS_DIV + 1);
  localparam logic [SW-1:0] SYNC_RST = {20'h00000, 4'hF, 1'b1, IO_BASE_FACTORY,
    WAIT_FACTORY, MEM_SEG_FACTORY, 3'h7, 2'h0};
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_HOLD = 3'b100
  } wait_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, preset to factory switch values
  logic [SW-1:0] sync_a, sync_b;
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      sync_a <= SYNC_RST;
      sync_b <= SYNC_RST;
    end
    else
    begin
      sync_a <= {sa_i, ior_n_i, iow_n_i, memr_n_i, memw_n_i, aen_i,
        io_base_wait_switch_i, wait_count_switch_i, memory_segment_switch_i,
        dack_n_i, ctrl_drq_i, ctrl_irq_i};
      sync_b <= sync_a;
    end
  end

  logic [19:0] addr;
  logic ior_n, iow_n, memr_n, memw_n, aen, drq, irq;
  logic [4:0] io_sw, mem_sw;
  logic [1:0] wait_sw;
  logic [3:1] dack_n;
  assign {addr, ior_n, iow_n, memr_n, memw_n, aen, io_sw, wait_sw, mem_sw,
    dack_n, drq, irq} = sync_b;

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [1:0] control, next_control;
  logic [2:0] dma_ch, next_dma_ch, irq_lvl, next_irq_lvl;
  logic [31:0] next_prdata;
  wait_state_e state, next_state;
  logic io_hit, mem_hit;
  logic [2:0] wr_dma, wr_irq;
  assign wr_dma = pwdata[2:0];
  assign wr_irq = pwdata[ROUTE_IRQ_LSB+2:ROUTE_IRQ_LSB];
  assign pready = 1'b1;
  assign pslverr = psel && penable &&
    !(paddr == REG_STATUS || paddr == REG_CONTROL || paddr == REG_ROUTE);

  always_comb
  begin
    next_control = control;
    next_dma_ch = dma_ch;
    next_irq_lvl = irq_lvl;
    next_prdata = prdata;
    if (psel && !penable)
    begin
      // Read data prepared in setup, valid through the access phase
      case (paddr)
        REG_STATUS: next_prdata = {17'h0, mem_hit, io_hit, state[1], mem_sw,
          wait_sw, io_sw};
        REG_CONTROL: next_prdata = {30'h0, control};
        REG_ROUTE: next_prdata = {25'h0, irq_lvl, 1'b0, dma_ch};
        default: next_prdata = 32'h00000000;
      endcase
    end
    if (psel && penable && pwrite)
    begin
      if (paddr == REG_CONTROL)
        next_control = pwdata[1:0];
      // Out-of-range channel or level writes keep the old value
      if (paddr == REG_ROUTE && wr_dma >= DMA_CH_MIN && wr_dma <= DMA_CH_MAX)
        next_dma_ch = wr_dma;
      if (paddr == REG_ROUTE && wr_irq >= IRQ_MIN && wr_irq <= IRQ_MAX)
        next_irq_lvl = wr_irq;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      control <= CONTROL_RESET;
      dma_ch <= DMA_CH_FACTORY;
      irq_lvl <= IRQ_FACTORY;
      prdata <= 32'h00000000;
    end
    else
    begin
      control <= next_control;
      dma_ch <= next_dma_ch;
      irq_lvl <= next_irq_lvl;
      prdata <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  decode_s next_decode;
  logic [13:0] mofs;
  assign mofs = addr[13:0];
  assign io_hit = control[0] && !aen && (!ior_n || !iow_n) && addr[IO_TOP_BIT]
    && addr[IO_HI_MSB:IO_TOP_BIT+1] == '0 && addr[8:4] == io_sw;
  assign mem_hit = control[1] && addr[MEM_TOP_BIT] && addr[18:14] == mem_sw
    && ((!memr_n && mofs < ROM_LIMIT)
    || ((!memr_n || !memw_n) && mofs >= RAM_BASE && mofs < RAM_LIMIT));
  always_comb
  begin
    next_decode = '0;
    next_decode.dout_lo = io_hit && addr[3:0] == DOUT_LO_OFS;
    next_decode.dout_hi = io_hit && addr[3:0] == DOUT_HI_OFS;
    next_decode.ctrl_cs = io_hit && addr[CTRL_SEL_BIT];
    next_decode.ctrl_reg = addr[2:0];
    next_decode.rom_cs = mem_hit && mofs < ROM_LIMIT;
    next_decode.ram_cs = mem_hit && mofs >= RAM_BASE;
    next_decode.mem_ofs = mofs[12:0];
    next_decode.rd = io_hit ? !ior_n : (mem_hit && !memr_n);
    next_decode.wr = io_hit ? !iow_n : (mem_hit && !memw_n);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      decode_o <= '0;
    else
      decode_o <= next_decode;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wait-state generator, bus clock from a restarted divider
  logic hit, hit_q, start, tick;
  logic [2:0] wcnt, next_wcnt, wait_n;
  logic [DW-1:0] div, next_div;
  assign hit = io_hit || mem_hit;
  assign start = hit && !hit_q;
  assign wait_n = {wait_sw, 1'b0};
  assign tick = div == '0;
  always_comb
  begin
    next_state = state;
    next_wcnt = wcnt;
    next_div = tick ? DW'(BUS_DIV - 1) : div - 1'b1;
    case (state)
      ST_IDLE:
        if (start && wait_n != '0)
        begin
          next_state = ST_WAIT;
          next_wcnt = wait_n;
          next_div = DW'(BUS_DIV - 1);
        end
      ST_WAIT:
        if (tick)
        begin
          next_wcnt = wcnt - 1'b1;
          if (wcnt == 3'h1)
            next_state = ST_HOLD;
        end
      ST_HOLD:
        if (!hit)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      state <= ST_IDLE;
      wcnt <= 3'h0;
      div <= '0;
      hit_q <= 1'b0;
    end
    else
    begin
      state <= next_state;
      wcnt <= next_wcnt;
      div <= next_div;
      hit_q <= hit;
    end
  end

  // Open-drain channel ready: pulled low only while waiting
  assign chrdy_o = 1'b0;
  assign chrdy_oe_n_o = state != ST_WAIT;

  ////////////////////////////////////////////////////////////////////////////
  // DMA and interrupt routing, one channel and one level
  logic [3:1] next_req;
  logic [7:2] next_irq;
  logic [3:1] ack_hit;
  genvar gi;
  for (gi = 1; gi <= 3; gi++)
  begin : g_dma
    assign next_req[gi] = drq && dma_ch == 3'(gi);
    assign ack_hit[gi] = !dack_n[gi] && dma_ch == 3'(gi);
  end
  for (gi = 2; gi <= 7; gi++)
  begin : g_irq
    assign next_irq[gi] = irq && irq_lvl == 3'(gi);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      dma_req_o <= '0;
      irq_line_o <= '0;
      ctrl_dack_o <= 1'b0;
    end
    else
    begin
      dma_req_o <= next_req;
      irq_line_o <= next_irq;
      ctrl_dack_o <= |ack_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [15:0] low_cnt;
  logic [2:0] wait_lat;
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || state != ST_WAIT)
      low_cnt <= 16'h0000;
    else
      low_cnt <= low_cnt + 1'b1;
    if (state == ST_IDLE)
      wait_lat <= wait_n;
  end

  sequence s_wait_begin;
    state == ST_IDLE && start && wait_n != '0;
  endsequence
  sequence s_wait_end;
    state == ST_WAIT ##1 state == ST_HOLD;
  endsequence
  a_io_window: assert property (decode_o.ctrl_cs || decode_o.dout_lo |->
    $past(addr[IO_TOP_BIT]) && $past(addr[IO_HI_MSB:IO_TOP_BIT+1]) == '0)
    else $error("io select outside window");
  a_io_compare: assert property (decode_o.dout_hi || decode_o.ctrl_cs |->
    $past(addr[8:4]) == $past(io_sw)) else $error("io base compare mismatch");
  a_dout_bytes: assert property (decode_o.dout_lo || decode_o.dout_hi |->
    $past(addr[3:1]) == 3'h0) else $error("output byte at wrong offset");
  a_ctrl_regs: assert property (decode_o.ctrl_cs |->
    $past(addr[CTRL_SEL_BIT]) && decode_o.ctrl_reg == $past(addr[2:0]))
    else $error("controller select at wrong offset");
  a_factory_cfg: assert property ($past(!rst_n_i) |-> io_sw == IO_BASE_FACTORY
    && wait_sw == WAIT_FACTORY && mem_sw == MEM_SEG_FACTORY)
    else $error("factory configuration lost at reset");
  a_wait_enter: assert property (s_wait_begin |=> !chrdy_oe_n_o)
    else $error("channel ready not pulled on access");
  a_wait_length: assert property (s_wait_end |->
    $past(low_cnt) == 16'(wait_lat) * 16'(BUS_DIV) - 16'h0001)
    else $error("wait length wrong");
  a_mem_window: assert property (decode_o.rom_cs || decode_o.ram_cs |->
    $past(addr[MEM_TOP_BIT]) && $past(addr[18:14]) == $past(mem_sw))
    else $error("memory select outside segment");
  a_rom_ram: assert property (decode_o.ram_cs |-> $past(mofs[13:11]) == 3'h4
    && !decode_o.rom_cs) else $error("ram select outside 2K window");
  a_rom_ro: assert property (decode_o.rom_cs |-> decode_o.rd && !decode_o.wr)
    else $error("rom selected on write");
  a_dma_pair: assert property ($past(drq) && !$past(rst_n_i) == 1'b0 |->
    dma_req_o == 3'(1 << ($past(dma_ch) - 1)))
    else $error("dma request on wrong channel");
  a_irq_route: assert property (irq_line_o != '0 |->
    $onehot(irq_line_o) && irq_line_o[$past(irq_lvl)])
    else $error("interrupt on wrong level");
endmodule

/* sim/isa_host_model.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////
// Host bus master: runs one strobed cycle, stretched by channel ready
module isa_host_model
  import isa_decode_pkg::*;
(
  // Clock and card feedback
  input wire logic clk_i,
  input wire logic chrdy_oe_n_i,
  input decode_s decode_i,
  // Host pins {memw,memr,iow,ior}
  output logic [19:0] sa_o,
  output logic [3:0] strobe_n_o
);
  // Idle bus
  initial
  begin
    sa_o = 20'h00000;
    strobe_n_o = 4'hF;
  end

  // Low-ready cycles are counted; -1 marks a hung cycle
  task automatic cycle(input logic [19:0] a, input int k, output decode_s seen, output int low);
    int n;
    low = 0;
    @(posedge clk_i);
    sa_o <= a;
    strobe_n_o <= ~(4'h1 << k);
    for (n = 0; n < 200 && (n < 6 || chrdy_oe_n_i !== 1'b1); n++)
    begin
      @(posedge clk_i);
      if (n == 4)
        seen = decode_i;
      if (chrdy_oe_n_i === 1'b0)
        low++;
    end
    if (n == 200)
      low = -1;
    strobe_n_o <= 4'hF;
    sa_o <= ~a; // Released lines stop showing the old address
    repeat (5) @(posedge clk_i);
  endtask
endmodule

/* sim/test_isa_card_address_decoder.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////
module test_isa_card_address_decoder
  import isa_decode_pkg::*;
;
  localparam int DIV = 2;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [19:0] sa;
  logic [3:0] strb_n;
  logic aen = 1'b0;
  logic [3:1] dack_n = 3'h7;
  logic [4:0] io_sw = IO_BASE_FACTORY;
  logic [1:0] wsw = WAIT_FACTORY;
  logic [4:0] mem_sw = MEM_SEG_FACTORY;
  logic drq = 1'b0;
  logic irq = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:1] dma_req;
  logic [7:2] irq_line;
  logic chrdy, chrdy_oe_n, dack, pready, pslverr, e;
  logic [31:0] prdata, r;
  decode_s dec, s;
  int fails = 0;
  int samples_checked = 0;
  int low, k, i;
  logic [19:0] a;
  logic [4:0] sw;
  logic [2:0] x;

  // Clock
  always #10 core_clk_i = ~core_clk_i;

  ////////////////////////////////////////////////////////////////
  isa_host_model host (.clk_i(core_clk_i), .chrdy_oe_n_i(chrdy_oe_n), .decode_i(dec),
    .sa_o(sa), .strobe_n_o(strb_n));

  isa_card_decoder #(.BUS_DIV(DIV)) dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .sa_i(sa), .ior_n_i(strb_n[0]), .iow_n_i(strb_n[1]), .memr_n_i(strb_n[2]),
    .memw_n_i(strb_n[3]), .aen_i(aen), .dack_n_i(dack_n), .dma_req_o(dma_req),
    .irq_line_o(irq_line), .chrdy_o(chrdy), .chrdy_oe_n_o(chrdy_oe_n),
    .io_base_wait_switch_i(io_sw), .wait_count_switch_i(wsw),
    .memory_segment_switch_i(mem_sw), .ctrl_drq_i(drq), .ctrl_irq_i(irq),
    .ctrl_dack_o(dack), .decode_o(dec), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  ////////////////////////////////////////////////////////////////
  // Compare and verdict
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task final_report;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // APB transfer held until pready
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge core_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge core_clk_i);
      if (pready === 1'b1)
        break;
    end
    if (n == 50)
    begin
      fails++;
      final_report();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Host cycle; a hung cycle counts as a mismatch and ends the run
  task hcyc(input logic [19:0] ad, input int kk);
    host.cycle(ad, kk, s, low);
    if (low < 0)
    begin
      fails++;
      final_report();
    end
  endtask

  // Expected {dout_lo,dout_hi,ctrl_cs}
  function automatic logic [2:0] io_exp(logic [4:0] b, logic [19:0] ad, logic blk);
    logic hit;
    hit = ad[19:9] == 11'h001 && ad[8:4] == b && !blk;
    return {hit && ad[3:0] == 4'h0, hit && ad[3:0] == 4'h1, hit && ad[3]};
  endfunction

  // Expected {rom_cs,ram_cs}
  function automatic logic [1:0] mem_exp(logic [4:0] b, logic [19:0] ad, int kk);
    logic hit;
    hit = ad[19] && ad[18:14] == b;
    return {hit && ad[13:0] < ROM_LIMIT && kk == 2,
      hit && ad[13:0] >= RAM_BASE && ad[13:0] < RAM_LIMIT};
  endfunction

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    void'($urandom(32'hf93d));
    repeat (6) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, REG_ROUTE, 32'h0);
    chk(r, 32'h71);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(r, {20'h00000, MEM_SEG_FACTORY, WAIT_FACTORY, IO_BASE_FACTORY});
    hcyc(20'h002B8, 0);
    chk({s.ctrl_cs, s.ctrl_reg, s.rd}, 5'h11);
    chk(low, 0);
    hcyc(20'hD0004, 2);
    chk({s.rom_cs, s.mem_ofs}, {1'b1, 13'h0004});
    $display("test factory done");
    for (i = 0; i < 24; i++)
    begin
      sw = 5'($urandom);
      io_sw <= sw;
      aen <= (i == 5);
      k = $urandom_range(1);
      a = (i < 16) ? {11'h001, sw, 4'(i)} : 20'($urandom_range(16'h0FFF));
      hcyc(a, k);
      chk({s.dout_lo, s.dout_hi, s.ctrl_cs}, io_exp(sw, a, i == 5));
      if (s.ctrl_cs === 1'b1)
        chk({s.ctrl_reg, s.rd, s.wr}, {a[2:0], k == 0, k == 1});
    end
    aen <= 1'b0;
    $display("test io decode done");
    for (i = 0; i < 4; i++)
    begin
      wsw <= 2'(i);
      hcyc({11'h001, sw, 4'h9}, 0);
      chk(low, 2 * i * DIV);
      chk(chrdy, 0);
    end
    $display("test wait done");
    for (i = 0; i < 16; i++)
    begin
      sw = 5'($urandom);
      mem_sw <= sw;
      k = 2 + $urandom_range(1);
      x = 3'(i);
      a = {i != 6, sw, (i < 6) ? 14'h2000 * x[1:0] + 14'h07FF * x[2] : 14'($urandom)};
      hcyc(a, k);
      chk({s.rom_cs, s.ram_cs}, mem_exp(sw, a, k));
      if (s.rom_cs === 1'b1 || s.ram_cs === 1'b1)
        chk(s.mem_ofs, a[12:0]);
    end
    $display("test memory done");
    apb(1'b1, REG_CONTROL, 32'h0);
    hcyc({11'h001, io_sw, 4'h8}, 0);
    chk(s.ctrl_cs, 0);
    apb(1'b1, REG_CONTROL, 32'h3);
    apb(1'b0, 8'hFC, 32'h0);
    chk(e, 1);
    for (i = 0; i < 6; i++)
    begin
      k = 1 + i % 3;
      apb(1'b1, REG_ROUTE, (32'(i + 2) << ROUTE_IRQ_LSB) | 32'(k));
      drq <= 1'b1;
      irq <= 1'b1;
      dack_n <= ~(3'h1 << (k - 1));
      repeat (5) @(posedge core_clk_i);
      chk(dma_req, 32'(1) << (k - 1));
      chk(dack, 1);
      chk(irq_line, 32'(1) << i);
      drq <= 1'b0;
      irq <= 1'b0;
      dack_n <= 3'h7;
      repeat (5) @(posedge core_clk_i);
      chk({dma_req, irq_line, dack}, 0);
    end
    $display("test routing done");
    final_report();
  end
endmodule
